// ===== src/leaky_bucket_activity_monitor.sv
// Leaky-bucket activity monitor top with Avalon-MM registers and interrupt
`timescale 1ns/1ns
module leaky_bucket_activity_monitor #(
  parameter int unsigned CYCLE_CLKS = lb_pkg::MON_CYCLE_CLKS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Monitored input quality
  input wire logic input_bad,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Status
  output logic inactivity_alarm,
  output logic irq
);
  import lb_pkg::*;

  logic [31:0] div_cnt;
  logic cycle_tick;
  logic bad_latched;
  logic cycle_fail;
  lb_cfg_s cfg;
  logic [7:0] level;
  logic at_max;
  logic at_max_q;
  alarm_e alarm_state;
  alarm_e next_alarm_state;
  logic [EV_W-1:0] irq_status;
  logic [EV_W-1:0] irq_mask;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic ack;
  logic wr_go;
  logic wr_lane0;
  logic [31:0] rd_mux;

  // Monitoring cycle divider
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 32'h0;
    end else if (cycle_tick) begin
      div_cnt <= 32'h0;
    end else begin
      div_cnt <= div_cnt + 32'h1;
    end
  end

  assign cycle_tick = (div_cnt >= 32'(CYCLE_CLKS - 1));

  // A glitch anywhere in the cycle marks the whole cycle bad
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bad_latched <= 1'b0;
    end else if (cycle_tick) begin
      bad_latched <= 1'b0;
    end else if (input_bad) begin
      bad_latched <= 1'b1;
    end
  end

  assign cycle_fail = bad_latched | input_bad;

  lb_accum u_accum (
    .core_clk(core_clk),
    .rst(rst),
    .cycle_tick(cycle_tick),
    .cycle_fail(cycle_fail),
    .cfg(cfg),
    .level(level),
    .at_max(at_max)
  );

  // Alarm with hysteresis; a reach of the set limit wins if limits overlap
  always_comb begin
    next_alarm_state = alarm_state;
    unique case (alarm_state)
      ALARM_IDLE: begin
        if (level >= cfg.set_limit) begin
          next_alarm_state = ALARM_RAISED;
        end
      end
      ALARM_RAISED: begin
        if ((level <= cfg.clear_limit) && (level < cfg.set_limit)) begin
          next_alarm_state = ALARM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarm_state <= ALARM_IDLE;
    end else begin
      alarm_state <= next_alarm_state;
    end
  end

  assign inactivity_alarm = (alarm_state == ALARM_RAISED);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      at_max_q <= 1'b0;
    end else begin
      at_max_q <= at_max;
    end
  end

  // Bus handshake: one wait cycle, answer on the second cycle
  assign waitrequest = (read | write) & ~ack;
  assign wr_go = write & ack;
  assign wr_lane0 = wr_go & byteenable[0];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (read | write) & ~ack;
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg.leak_code <= RST_LEAK_CODE;
      cfg.set_limit <= RST_ALARM_SET_LIMIT;
      cfg.clear_limit <= RST_ALARM_CLEAR_LIMIT;
      cfg.bucket_max <= RST_BUCKET_SIZE;
    end else if (wr_lane0) begin
      case (address)
        ADDR_LEAK_RATE_CFG0: cfg.leak_code <= writedata[LEAK_CODE_MSB:LEAK_CODE_LSB];
        ADDR_ALARM_SET_LIMIT_CFG1: cfg.set_limit <= writedata[7:0];
        ADDR_ALARM_CLEAR_LIMIT_CFG1: cfg.clear_limit <= writedata[7:0];
        ADDR_BUCKET_SIZE: cfg.bucket_max <= writedata[7:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_mask <= '0;
    end else if (wr_lane0 && (address == ADDR_IRQ_MASK)) begin
      irq_mask <= writedata[EV_W-1:0];
    end
  end

  // Sticky events; a new event beats a simultaneous write-one clear
  always_comb begin
    ev_set = '0;
    ev_set[EV_ALARM_SET] = (alarm_state == ALARM_IDLE) && (next_alarm_state == ALARM_RAISED);
    ev_set[EV_ALARM_CLEAR] = (alarm_state == ALARM_RAISED) && (next_alarm_state == ALARM_IDLE);
    ev_set[EV_BUCKET_FULL] = at_max & ~at_max_q;
  end

  assign ev_clr = (wr_lane0 && (address == ADDR_IRQ_STATUS)) ? writedata[EV_W-1:0] : '0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~ev_clr) | ev_set;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_mux = 32'h0;
    case (address)
      ADDR_LEAK_RATE_CFG0: rd_mux[LEAK_CODE_MSB:LEAK_CODE_LSB] = cfg.leak_code;
      ADDR_ALARM_SET_LIMIT_CFG1: rd_mux[7:0] = cfg.set_limit;
      ADDR_ALARM_CLEAR_LIMIT_CFG1: rd_mux[7:0] = cfg.clear_limit;
      ADDR_BUCKET_SIZE: rd_mux[7:0] = cfg.bucket_max;
      ADDR_IRQ_STATUS: rd_mux[EV_W-1:0] = irq_status;
      ADDR_IRQ_MASK: rd_mux[EV_W-1:0] = irq_mask;
      ADDR_MONITOR_STATE: begin
        rd_mux[STATE_LEVEL_MSB:STATE_LEVEL_LSB] = level;
        rd_mux[STATE_ALARM_BIT] = inactivity_alarm;
        rd_mux[STATE_FULL_BIT] = at_max;
      end
      default: rd_mux = 32'h0;
    endcase
  end

  // Captured in the wait cycle so it stands through the answer cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0;
    end else if (read && !ack) begin
      readdata <= rd_mux;
    end
  end

  property p_raise;
    @(posedge core_clk) disable iff (rst)
    !inactivity_alarm && (level >= cfg.set_limit) |=> inactivity_alarm;
  endproperty
  a_raise: assert property (p_raise) else $error("alarm not raised at set limit");

  property p_no_early_raise;
    @(posedge core_clk) disable iff (rst)
    !inactivity_alarm && (level < cfg.set_limit) |=> !inactivity_alarm;
  endproperty
  a_no_early_raise: assert property (p_no_early_raise) else $error("alarm raised below limit");

  property p_clear;
    @(posedge core_clk) disable iff (rst)
    inactivity_alarm && (level <= cfg.clear_limit) && (level < cfg.set_limit) |=> !inactivity_alarm;
  endproperty
  a_clear: assert property (p_clear) else $error("alarm not cleared at clear limit");

  property p_hold;
    @(posedge core_clk) disable iff (rst)
    inactivity_alarm && (level > cfg.clear_limit) |=> inactivity_alarm;
  endproperty
  a_hold: assert property (p_hold) else $error("alarm dropped above clear limit");

  property p_bad_caught;
    @(posedge core_clk) disable iff (rst)
    input_bad && !cycle_tick |=> cycle_fail || $past(div_cnt) >= 32'(CYCLE_CLKS - 1);
  endproperty
  a_bad_caught: assert property (p_bad_caught) else $error("bad input lost in cycle");

  property p_bus_answer;
    @(posedge core_clk) disable iff (rst)
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

  property p_event_sticky;
    @(posedge core_clk) disable iff (rst)
    $rose(inactivity_alarm) |-> irq_status[EV_ALARM_SET];
  endproperty
  a_event_sticky: assert property (p_event_sticky) else $error("alarm event not recorded");

  c_raise: cover property (@(posedge core_clk) disable iff (rst) $rose(inactivity_alarm));
  c_clear: cover property (@(posedge core_clk) disable iff (rst) $fell(inactivity_alarm));
  c_full: cover property (@(posedge core_clk) disable iff (rst) $rose(at_max));
  c_irq: cover property (@(posedge core_clk) disable iff (rst) $rose(irq));

endmodule : leaky_bucket_activity_monitor

// ===== include/lb_pkg.sv
// Constants, register map and types for the leaky-bucket activity monitor
package lb_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_LEAK_RATE_CFG0 = 8'h50;
  localparam logic [7:0] ADDR_ALARM_SET_LIMIT_CFG1 = 8'h54;
  localparam logic [7:0] ADDR_ALARM_CLEAR_LIMIT_CFG1 = 8'h58;
  localparam logic [7:0] ADDR_BUCKET_SIZE = 8'h5c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h60;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h64;
  localparam logic [7:0] ADDR_MONITOR_STATE = 8'h68;

  // Values after reset
  localparam logic [1:0] RST_LEAK_CODE = 2'h1;
  localparam logic [7:0] RST_ALARM_SET_LIMIT = 8'h06;
  localparam logic [7:0] RST_ALARM_CLEAR_LIMIT = 8'h04;
  localparam logic [7:0] RST_BUCKET_SIZE = 8'h08;

  // Field positions
  localparam int LEAK_CODE_LSB = 0;
  localparam int LEAK_CODE_MSB = 1;
  localparam int STATE_LEVEL_LSB = 0;
  localparam int STATE_LEVEL_MSB = 7;
  localparam int STATE_ALARM_BIT = 8;
  localparam int STATE_FULL_BIT = 9;

  // Interrupt events, one bit each in status and mask
  localparam int EV_W = 3;
  localparam int EV_ALARM_SET = 0;
  localparam int EV_ALARM_CLEAR = 1;
  localparam int EV_BUCKET_FULL = 2;

  // Timing: one monitoring cycle equals the fastest leak period
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MON_CYCLE_MS = 128;
  localparam int unsigned MON_CYCLE_CLKS = MON_CYCLE_MS * 1000000 / CLK_PERIOD_NS;

  typedef struct packed {
    logic [1:0] leak_code;
    logic [7:0] set_limit;
    logic [7:0] clear_limit;
    logic [7:0] bucket_max;
  } lb_cfg_s;

  typedef enum logic {
    ALARM_IDLE = 1'b0,
    ALARM_RAISED = 1'b1
  } alarm_e;

endpackage : lb_pkg

// ===== src/lb_accum.sv
// Saturating leaky-bucket accumulator with programmable leak run length
`timescale 1ns/1ns
module lb_accum (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Monitoring cycle result
  input wire logic cycle_tick,
  input wire logic cycle_fail,
  // Configuration
  input wire lb_pkg::lb_cfg_s cfg,
  // Bucket state
  output logic [7:0] level,
  output logic at_max
);
  import lb_pkg::*;

  logic [2:0] good_run;
  logic [2:0] run_last;
  logic run_done;
  logic [2:0] run_ref;

  // Run length 1, 2, 4 or 8 good cycles per leak
  assign run_last = 3'((4'h1 << cfg.leak_code) - 4'h1);
  // Greater-or-equal so a shortened run after a code change ends promptly
  assign run_done = (good_run >= run_last);
  assign at_max = (level >= cfg.bucket_max);

  // Separate run table so the run-length check does not reuse the shift above
  always_comb begin
    run_ref = 3'h0;
    unique case (cfg.leak_code)
      2'h0: run_ref = 3'h0;
      2'h1: run_ref = 3'h1;
      2'h2: run_ref = 3'h3;
      2'h3: run_ref = 3'h7;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      good_run <= 3'h0;
    end else if (cycle_tick) begin
      if (cycle_fail || run_done) begin
        good_run <= 3'h0;
      end else begin
        good_run <= good_run + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      level <= 8'h00;
    end else if (cycle_tick) begin
      if (cycle_fail) begin
        if (level < cfg.bucket_max) begin
          level <= level + 8'h01;
        end
      end else if (run_done && (level != 8'h00)) begin
        level <= level - 8'h01;
      end
    end
  end

  property p_fill;
    @(posedge core_clk) disable iff (rst)
    cycle_tick && cycle_fail && (level < cfg.bucket_max) |=> level == $past(level) + 8'h01;
  endproperty
  a_fill: assert property (p_fill) else $error("bucket missed a fill");

  property p_leak;
    @(posedge core_clk) disable iff (rst)
    cycle_tick && !cycle_fail && run_done && (level != 8'h00) |=> level == $past(level) - 8'h01;
  endproperty
  a_leak: assert property (p_leak) else $error("bucket missed a leak");

  property p_no_early_leak;
    @(posedge core_clk) disable iff (rst)
    cycle_tick && !cycle_fail && (good_run < run_last) |=> $stable(level);
  endproperty
  a_no_early_leak: assert property (p_no_early_leak) else $error("bucket leaked too soon");

  property p_run_len;
    @(posedge core_clk) disable iff (rst)
    (level < $past(level)) |-> $past(good_run) >= $past(run_ref);
  endproperty
  a_run_len: assert property (p_run_len) else $error("leak run length wrong");

  property p_ceiling;
    @(posedge core_clk) disable iff (rst)
    cycle_tick && cycle_fail && (level >= cfg.bucket_max) |=> $stable(level);
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("bucket overfilled");

  property p_floor;
    @(posedge core_clk) disable iff (rst)
    (level == 8'h00) && !(cycle_tick && cycle_fail) |=> level == 8'h00;
  endproperty
  a_floor: assert property (p_floor) else $error("bucket went below zero");

endmodule : lb_accum

// ===== verification/lb_ref_source.sv
// Behavioural model of the watched reference source
`timescale 1ns/1ns
module lb_ref_source (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Requested quality
  input wire logic fail_en,
  // Quality as seen by the monitor
  output logic input_bad
);
  // Registered, so quality changes land just after an edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      input_bad <= 1'b0;
    end else begin
      input_bad <= fail_en;
    end
  end
endmodule : lb_ref_source

// ===== verification/leaky_bucket_activity_monitor_test.sv
// Self-checking bench for the leaky-bucket activity monitor
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module leaky_bucket_activity_monitor_test;
  import lb_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic fail_en = 1'b0;
  logic input_bad;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  logic inactivity_alarm;
  logic irq;
  int errors = 0;
  int checks = 0;
  int n;
  int m;
  logic [31:0] seed = 32'h9fa9;
  logic [31:0] r;
  logic [31:0] exp_q[$];
  logic [31:0] exp_v;

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  lb_ref_source src (.core_clk(core_clk), .rst(rst), .fail_en(fail_en), .input_bad(input_bad));

  // Short monitoring cycle keeps the run brief
  leaky_bucket_activity_monitor #(.CYCLE_CLKS(4)) dut (
    .core_clk(core_clk), .rst(rst), .input_bad(input_bad), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .inactivity_alarm(inactivity_alarm), .irq(irq));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // One Avalon transfer; reads note their expected data
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    int k;
    k = 0;
    if (!w) begin
      exp_q.push_back(e);
    end
    @(posedge core_clk);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= d;
    do begin
      @(posedge core_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      errors++;
      tally_and_finish();
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wait_alarm(input logic v, output int c);
    c = 0;
    while (inactivity_alarm !== v && c < 2000) begin
      @(posedge core_clk);
      c++;
    end
    if (c >= 2000) begin
      errors++;
      tally_and_finish();
    end
  endtask : wait_alarm

  // Read data taken at the edge where waitrequest is low
  always @(posedge core_clk) begin
    if (read && waitrequest === 1'b0) begin
      exp_v = exp_q.pop_front();
      `CHK("readdata", exp_v, readdata)
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    bus(1'b0, ADDR_LEAK_RATE_CFG0, 32'h0, 32'h1);
    bus(1'b0, ADDR_ALARM_SET_LIMIT_CFG1, 32'h0, 32'h6);
    bus(1'b0, ADDR_ALARM_CLEAR_LIMIT_CFG1, 32'h0, 32'h4);
    bus(1'b0, ADDR_MONITOR_STATE, 32'h0, 32'h0);
    bus(1'b0, ADDR_BUCKET_SIZE, 32'h0, 32'h8);
    r = xs();
    bus(1'b1, ADDR_ALARM_SET_LIMIT_CFG1, r, 32'h0);
    bus(1'b0, ADDR_ALARM_SET_LIMIT_CFG1, 32'h0, {24'h0, r[7:0]});
    // Lane 0 disabled, so the write must be dropped
    byteenable <= 4'he;
    bus(1'b1, ADDR_ALARM_SET_LIMIT_CFG1, ~r, 32'h0);
    byteenable <= 4'hf;
    bus(1'b0, ADDR_ALARM_SET_LIMIT_CFG1, 32'h0, {24'h0, r[7:0]});
    r = xs();
    bus(1'b1, ADDR_LEAK_RATE_CFG0, r, 32'h0);
    bus(1'b0, ADDR_LEAK_RATE_CFG0, 32'h0, {30'h0, r[1:0]});
    bus(1'b0, 8'h70, 32'h0, 32'h0);
    bus(1'b1, ADDR_ALARM_SET_LIMIT_CFG1, 32'h6, 32'h0);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, ADDR_LEAK_RATE_CFG0, 32'(c), 32'h0);
      fail_en <= 1'b1;
      wait_alarm(1'b1, n);
      `CHK("raise_clks", 1'b1, n >= 20 && n <= 30)
      repeat (40) @(posedge core_clk);
      bus(1'b0, ADDR_MONITOR_STATE, 32'h0, 32'h308);
      fail_en <= 1'b0;
      wait_alarm(1'b0, n);
      // Four leaks from the cap down to the clear limit
      `CHK("clear_clks", 1'b1, n >= (16 << c) && n <= (16 << c) + 10)
      // Last bad tick lands 1 to 4 clocks after the release, then four runs of 4N clocks
      `CHK("leak_clks", 1'b1, n >= (16 << c) + 3 && n <= (16 << c) + 6)
      // Each code step doubles the leak time, so the clear time grows by 8N
      if (c > 0) begin
        `CHK("leak_ratio", 1'b1, n - m >= (8 << c) - 3 && n - m <= (8 << c) + 3)
      end
      m = n;
      bus(1'b0, ADDR_MONITOR_STATE, 32'h0, 32'h4);
      repeat ((16 << c) + 12) @(posedge core_clk);
    end
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0, 32'h7);
    `CHK("irq_masked", 1'b0, irq)
    bus(1'b1, ADDR_IRQ_MASK, 32'h7, 32'h0);
    @(posedge core_clk);
    `CHK("irq_on", 1'b1, irq)
    bus(1'b0, ADDR_IRQ_MASK, 32'h0, 32'h7);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h7, 32'h0);
    @(posedge core_clk);
    `CHK("irq_cleared", 1'b0, irq)
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0, 32'h0);
    bus(1'b0, ADDR_MONITOR_STATE, 32'h0, 32'h0);
    repeat (2) @(posedge core_clk);
    tally_and_finish();
  end
endmodule : leaky_bucket_activity_monitor_test
